// *** urx_pkg.sv ***
// Purpose: Shared constants for the receive event and wake logic
// Assumes: Single 50 MHz clock, sample enable supplied by the baud generator
// Notes:   Shared counts and the sampled CTS reset value live here
package urx_pkg;
   localparam int          URX_CLK_HZ      = 50000000;
   localparam int          URX_FIFO_DEPTH  = 8;
   localparam int          URX_BUF_DEPTH   = 16;
   localparam int          URX_LVL_W       = 4;
   localparam int          URX_CHAR_W      = 8;
   localparam int          URX_OVS_W       = 8;
   localparam logic [3:0]  URX_FULL_LEVEL  = 4'h8;
   localparam logic [3:0]  URX_TX_ONE_FROM = 4'h2;
   localparam logic [3:0]  URX_TX_ONE_TO   = 4'h1;
   localparam logic [3:0]  URX_TX_HALF     = 4'h4;
   localparam logic        URX_CTS_RESET   = 1'b1;
   localparam logic [2:0]  URX_BCLK_RDY_CNT = 3'h4;
   typedef enum logic [2:0] {
      URX_IDLE   = 3'b000,
      URX_START  = 3'b001,
      URX_DATA   = 3'b010,
      URX_PARITY = 3'b011,
      URX_STOP   = 3'b100
   } urx_state_t;
endpackage

// *** urx_fifo.sv ***
// Purpose: Parameterised FIFO with valid/ready on both sides
// Assumes: Synchronous clear, one clock
// Notes:   Level output counts stored words
`timescale 1ns/1ps
module urx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int LW    = 5
) (
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic             clear,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [LW-1:0]    level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic             push;
   logic             pop;
   assign in_ready  = (level != LW'(DEPTH));
   assign out_valid = (level != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   // Storage
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
   // Pointers and count
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level  <= '0;
      end else if (clear) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         level <= level + LW'(push) - LW'(pop);
      end
   end
endmodule

// *** urx_events.sv ***
// Purpose: Receive checking, event flags, wake conditions and peripheral reset
// Assumes: sample_en pulses once per oversample tick from the baud divider
// Notes:   Receive FIFO limited to a logical depth of eight in a 16-word buffer
//
// Overview of operation
// - Frame error when any bit sample invalid
// - Three samples per bit, start/stop/parity/data
// - Start 3/3 low, data 2/3, stop 3/3
// - Parity 3/3 match, polarity and odd select
// - Fractional double check: strict start, stop, parity
// - Parity error when computed parity mismatches
// - Without flow control CTS in, RTS out
// - CTS change flag on each sampled edge while flow control is off
// - Sampled CTS resets to one
// - Sample CTS while baud clock runs, unless disabled
// - Force sampled CTS one when clock stops
// - Overrun when valid frame meets full FIFO
// - Overrun flagged at stop, frame dropped
// - Threshold flag when count exceeds threshold
// - One-byte-remaining event on tx two to one
// - Half-empty flag on tx half plus one to half
// - Enabled wake source requests low-power exit; code raises the request only while fdm_en is set
// - Wake flags are levels gated by enables
// - Wake on threshold, full eight, not empty
// - Reset while disabled or until ready
// - Divisor or rate write resets when enabled
// - Three wake flags, each own enable
// - Three samples around mid bit
// - Interrupt when enabled flag set
`timescale 1ns/1ps
module urx_events
   import urx_pkg::*;
#(
   parameter int CHAR_W = URX_CHAR_W,
   parameter int DEPTH  = URX_FIFO_DEPTH
) (
   input  wire logic                  clock,
   input  wire logic                  rstn,
   input  wire logic                  sample_en,
   input  wire logic [URX_OVS_W-1:0]  ovs_ratio,
   input  wire logic                  rx_pin,
   input  wire logic                  cts_pin,
   input  wire logic                  rts_level,
   input  wire logic                  hfc_en,
   input  wire logic                  cts_dis,
   input  wire logic                  baud_clk_en,
   input  wire logic                  divisor_write,
   input  wire logic                  osr_write,
   input  wire logic                  fdm_en,
   input  wire logic                  dpfe_en,
   input  wire logic                  parity_en,
   input  wire logic                  parity_polarity_select,
   input  wire logic                  parity_odd_select,
   input  wire logic                  data_check_en,
   input  wire logic [URX_LVL_W-1:0]  rx_thd_val,
   input  wire logic [URX_LVL_W-1:0]  tx_level,
   input  wire logic                  rx_read,
   input  wire logic [5:0]            int_enable,
   input  wire logic [5:0]            int_clear,
   input  wire logic [2:0]            wake_enable,
   output logic                       rts_pin,
   output logic [CHAR_W-1:0]          rx_data,
   output logic                       rx_data_valid,
   output logic                       rx_data_parity_err,
   output logic [URX_LVL_W:0]         rx_level,
   output logic                       frame_error_flag,
   output logic                       parity_error_flag,
   output logic                       clear_to_send_change_flag,
   output logic                       overrun_flag,
   output logic                       rx_threshold_flag,
   output logic                       tx_half_empty_flag,
   output logic                       tx_one_left_pulse,
   output logic                       cts_sampled,
   output logic [2:0]                 wake_flag_register,
   output logic                       wake_request,
   output logic                       irq,
   output logic                       baud_clk_ready,
   output logic                       periph_in_reset
);
   urx_state_t                state;
   logic [URX_OVS_W-1:0]      tick;
   logic [2:0]                bit_idx;
   logic [2:0]                samp;
   logic [2:0]                win;
   logic [CHAR_W-1:0]         shreg;
   logic                      bad_bit;
   logic                      par_bit_err;
   logic [2:0]                rdy_cnt;
   logic                      soft_rst;
   logic [URX_LVL_W-1:0]      tx_level_d;
   logic                      frame_done;
   logic                      frame_good;
   logic [CHAR_W:0]           fifo_out;
   logic [URX_LVL_W:0]        buf_level;
   logic                      push;
   logic                      rx_full;
   logic [2:0]                wake_cond;
   logic                      is_mid;
   logic                      maj;
   logic                      all_hi;
   logic                      all_lo;
   logic                      expect_par;

   // Peripheral reset: disabled clock, pending ready, or divisor/rate write
   assign soft_rst = !baud_clk_en || !baud_clk_ready || divisor_write || osr_write;
   // Three samples straddle the bit middle
   assign is_mid   = sample_en && (tick >= (ovs_ratio >> 1) - 8'h01)
                     && (tick <= (ovs_ratio >> 1) + 8'h01);
   // The last sample may fall on the decision tick
   assign win      = (is_mid && tick == ovs_ratio - 8'h01) ? {samp[1:0], rx_pin} : samp;
   assign all_hi   = &win;
   assign all_lo   = ~|win;
   assign maj      = (win[0] & win[1]) | (win[1] & win[2]) | (win[0] & win[2]);
   // Expected parity: odd/even over ones or zeros
   assign expect_par = !parity_odd_select ^ (^shreg) ^ (parity_polarity_select & 1'(CHAR_W % 2));
   assign rx_full    = (buf_level >= (URX_LVL_W+1)'(DEPTH));
   assign frame_done = (state == URX_STOP) && sample_en && (tick == ovs_ratio - 8'h01);
   assign frame_good = frame_done && !bad_bit && all_hi;
   assign push       = frame_good && !rx_full && !soft_rst;

   // Baud ready: a few cycles after enable rises
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rdy_cnt        <= '0;
         baud_clk_ready <= 1'b0;
      end else if (!baud_clk_en) begin
         rdy_cnt        <= '0;
         baud_clk_ready <= 1'b0;
      end else if (!baud_clk_ready) begin
         rdy_cnt        <= rdy_cnt + 3'h1;
         baud_clk_ready <= (rdy_cnt == URX_BCLK_RDY_CNT);
      end
   end

   // Registered reset status
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         periph_in_reset <= 1'b1;
      end else begin
         periph_in_reset <= soft_rst;
      end
   end

   // Receive state machine with three samples per bit
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state   <= URX_IDLE;
         tick    <= '0;
         bit_idx <= '0;
         samp    <= '0;
         shreg   <= '0;
         bad_bit <= 1'b0;
         par_bit_err <= 1'b0;
      end else if (soft_rst) begin
         state   <= URX_IDLE;
         tick    <= '0;
      end else if (sample_en) begin
         if (is_mid) begin
            samp   <= {samp[1:0], rx_pin};
         end
         if (state != URX_IDLE) begin
            tick <= (tick == ovs_ratio - 8'h01) ? '0 : tick + 8'h01;
         end
         case (state)
            URX_IDLE: begin
               bad_bit     <= 1'b0;
               par_bit_err <= 1'b0;
               if (!rx_pin) begin
                  state <= URX_START;
                  tick  <= 8'h01;
               end
            end
            URX_START: begin
               if (tick == ovs_ratio - 8'h01) begin
                  bad_bit <= bad_bit | !all_lo;
                  bit_idx <= '0;
                  state   <= URX_DATA;
               end
            end
            URX_DATA: begin
               if (tick == ovs_ratio - 8'h01) begin
                  shreg   <= {maj, shreg[CHAR_W-1:1]};
                  bit_idx <= bit_idx + 3'h1;
                  if (bit_idx == 3'(CHAR_W-1)) begin
                     state <= parity_en ? URX_PARITY : URX_STOP;
                  end
               end
            end
            URX_PARITY: begin
               if (tick == ovs_ratio - 8'h01) begin
                  // All three parity samples must match the expected value
                  if (!(expect_par ? all_hi : all_lo)) begin
                     bad_bit <= 1'b1;
                  end
                  par_bit_err <= (maj != expect_par);
                  state <= URX_STOP;
               end
            end
            URX_STOP: begin
               if (tick == ovs_ratio - 8'h01) begin
                  state <= URX_IDLE;
               end
            end
            default: begin
               state <= URX_IDLE;
            end
         endcase
      end
   end

   // Receive buffer: 16 words, logically limited to eight
   urx_fifo #(
      .WIDTH (CHAR_W+1),
      .DEPTH (URX_BUF_DEPTH),
      .LW    (URX_LVL_W+1)
   ) u_rx_fifo (
      .clock     (clock),
      .rstn      (rstn),
      .clear     (soft_rst),
      .in_data   ({par_bit_err, shreg}),
      .in_valid  (push),
      .in_ready  (),
      .out_data  (fifo_out),
      .out_valid (),
      .out_ready (rx_read),
      .level     (buf_level)
   );

   // Registered read side
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rx_data            <= '0;
         rx_data_valid      <= 1'b0;
         rx_data_parity_err <= 1'b0;
         rx_level           <= '0;
      end else begin
         rx_data            <= fifo_out[CHAR_W-1:0];
         rx_data_parity_err <= fifo_out[CHAR_W];
         rx_data_valid      <= (buf_level != '0);
         rx_level           <= buf_level;
      end
   end

   // Sampled clear-to-send; request-to-send from rts_level, or FIFO not full when hfc_en is set
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cts_sampled <= URX_CTS_RESET;
         rts_pin     <= 1'b1;
      end else begin
         rts_pin <= hfc_en ? !rx_full : rts_level;
         if (!baud_clk_en) begin
            cts_sampled <= URX_CTS_RESET;
         end else if (!cts_dis) begin
            cts_sampled <= cts_pin;
         end
      end
   end

   // Transmit level history
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tx_level_d        <= '0;
         tx_one_left_pulse <= 1'b0;
      end else begin
         tx_level_d        <= tx_level;
         tx_one_left_pulse <= (tx_level_d == URX_TX_ONE_FROM) && (tx_level == URX_TX_ONE_TO);
      end
   end

   // Sticky event flags, set wins over clear
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         frame_error_flag          <= 1'b0;
         parity_error_flag         <= 1'b0;
         clear_to_send_change_flag <= 1'b0;
         overrun_flag              <= 1'b0;
         rx_threshold_flag         <= 1'b0;
         tx_half_empty_flag        <= 1'b0;
      end else begin
         frame_error_flag  <= (frame_done && (bad_bit || !all_hi))
                              || (frame_error_flag && !int_clear[0]);
         parity_error_flag <= (frame_done && parity_en && par_bit_err)
                              || (parity_error_flag && !int_clear[1]);
         clear_to_send_change_flag <= (!hfc_en && baud_clk_en && !cts_dis && (cts_pin != cts_sampled))
                              || (clear_to_send_change_flag && !int_clear[2]);
         overrun_flag      <= (frame_good && rx_full)
                              || (overrun_flag && !int_clear[3]);
         rx_threshold_flag <= (push && ((buf_level + 5'h01) > {1'b0, rx_thd_val}))
                              || (rx_threshold_flag && !int_clear[4]);
         tx_half_empty_flag <= ((tx_level_d == URX_TX_HALF + 4'h1) && (tx_level == URX_TX_HALF))
                              || (tx_half_empty_flag && !int_clear[5]);
      end
   end

   // Wake conditions are levels of the receive count
   assign wake_cond[0] = (buf_level >= {1'b0, rx_thd_val});
   assign wake_cond[1] = (buf_level >= {1'b0, URX_FULL_LEVEL});
   assign wake_cond[2] = (buf_level != '0);

   // Wake flags and request, interrupt output
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wake_flag_register <= '0;
         wake_request       <= 1'b0;
         irq                <= 1'b0;
      end else begin
         wake_flag_register <= wake_cond & wake_enable;
         wake_request       <= fdm_en && |(wake_cond & wake_enable);
         irq <= |({tx_half_empty_flag, rx_threshold_flag, overrun_flag,
                   clear_to_send_change_flag, parity_error_flag, frame_error_flag} & int_enable);
      end
   end
endmodule

// *** urx_events_props.sv ***
// Purpose: Concurrent checks on the receive event and wake logic ports
// Assumes: Single clock domain, asynchronous active-low reset
// Notes:   Bound to every instance of the event block
`timescale 1ns/1ps
module urx_events_props
   import urx_pkg::*;
(
   input wire logic                 clock,
   input wire logic                 rstn,
   input wire logic                 baud_clk_en,
   input wire logic                 baud_clk_ready,
   input wire logic                 periph_in_reset,
   input wire logic                 divisor_write,
   input wire logic                 osr_write,
   input wire logic                 hfc_en,
   input wire logic                 rts_level,
   input wire logic                 rts_pin,
   input wire logic                 cts_sampled,
   input wire logic [URX_LVL_W-1:0] tx_level,
   input wire logic                 tx_one_left_pulse,
   input wire logic                 tx_half_empty_flag,
   input wire logic [URX_LVL_W:0]   rx_level,
   input wire logic [2:0]           wake_enable,
   input wire logic [2:0]           wake_flag_register,
   input wire logic                 frame_error_flag,
   input wire logic [5:0]           int_enable,
   input wire logic                 irq
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   // Transmit level steps that trigger events
   sequence s_tx_two_to_one;
      tx_level == URX_TX_ONE_FROM ##1 tx_level == URX_TX_ONE_TO;
   endsequence
   sequence s_tx_half_step;
      tx_level == URX_TX_HALF + 4'h1 ##1 tx_level == URX_TX_HALF;
   endsequence
   property p_tx_one; s_tx_two_to_one |-> ##[0:1] tx_one_left_pulse; endproperty
   a_tx_one: assert property (p_tx_one) else $error("one-left pulse missing");
   property p_tx_half; s_tx_half_step |-> ##[0:1] tx_half_empty_flag; endproperty
   a_tx_half: assert property (p_tx_half) else $error("half-empty flag missing");
   // Wake flags follow held conditions
   property p_wake_ne; (wake_enable[2] && rx_level != 5'h00) [*2] |-> wake_flag_register[2]; endproperty
   a_wake_ne: assert property (p_wake_ne) else $error("not-empty wake missing");
   property p_wake_full; (wake_enable[1] && rx_level >= 5'h08) [*2] |-> wake_flag_register[1]; endproperty
   a_wake_full: assert property (p_wake_full) else $error("full wake missing");
   property p_wake_off; (!wake_enable[0]) [*2] |-> !wake_flag_register[0]; endproperty
   a_wake_off: assert property (p_wake_off) else $error("disabled wake flag set");
   // Peripheral reset sources
   property p_off_reset; (!baud_clk_en) [*2] |-> periph_in_reset; endproperty
   a_off_reset: assert property (p_off_reset) else $error("not held in reset while off");
   property p_not_ready; (baud_clk_en && !baud_clk_ready) [*2] |-> periph_in_reset; endproperty
   a_not_ready: assert property (p_not_ready) else $error("left reset before ready");
   property p_div_write; baud_clk_en && (divisor_write || osr_write) |-> ##[0:2] periph_in_reset; endproperty
   a_div_write: assert property (p_div_write) else $error("divisor write did not reset");
   // Clear-to-send, request-to-send and interrupt
   property p_cts_stop; $fell(baud_clk_en) |-> ##[0:3] cts_sampled; endproperty
   a_cts_stop: assert property (p_cts_stop) else $error("sampled cts not forced high");
   property p_rts; (!hfc_en && $stable(rts_level)) [*2] |-> rts_pin == rts_level; endproperty
   a_rts: assert property (p_rts) else $error("rts pin not following software");
   property p_irq; (frame_error_flag && int_enable[0]) [*2] |-> irq; endproperty
   a_irq: assert property (p_irq) else $error("enabled flag without interrupt");
endmodule

bind urx_events urx_events_props chk_u (
   .clock(clock), .rstn(rstn), .baud_clk_en(baud_clk_en), .baud_clk_ready(baud_clk_ready),
   .periph_in_reset(periph_in_reset), .divisor_write(divisor_write), .osr_write(osr_write),
   .hfc_en(hfc_en), .rts_level(rts_level), .rts_pin(rts_pin), .cts_sampled(cts_sampled),
   .tx_level(tx_level), .tx_one_left_pulse(tx_one_left_pulse), .tx_half_empty_flag(tx_half_empty_flag),
   .rx_level(rx_level), .wake_enable(wake_enable), .wake_flag_register(wake_flag_register),
   .frame_error_flag(frame_error_flag), .int_enable(int_enable), .irq(irq)
);

// *** urx_serial_dev.sv ***
// Purpose: Behavioural far-end serial device driving receive data and CTS
// Assumes: Caller sits on a falling clock edge; bit time in clock cycles
// Notes:   Line idles high between frames like a pulled-up serial line
`timescale 1ns/1ps
module urx_serial_dev #(
   parameter int BIT_CYC = 4
) (
   input  wire logic clock,
   output logic      rx_pin,
   output logic      cts_pin
);
   // Idle levels from time zero
   initial begin
      rx_pin = 1'b1;
      cts_pin = 1'b1;
   end
   // Hold one bit for a whole bit time
   task automatic put_bit(input logic b);
      rx_pin = b;
      repeat (BIT_CYC) @(negedge clock);
   endtask
   // Start, data least significant bit first, optional parity, stop
   task automatic send(input logic [7:0] d, input logic pe, input logic pb, input logic sb);
      put_bit(1'b0);
      for (int i = 0; i < 8; i++) begin
         put_bit(d[i]);
      end
      if (pe) begin
         put_bit(pb);
      end
      put_bit(sb);
      rx_pin = 1'b1;
   endtask
   // Change of the clear-to-send line
   task automatic set_cts(input logic v);
      cts_pin = v;
   endtask
endmodule

// *** urx_events_tb.sv ***
// Purpose: Self-checking bench for the receive event and wake logic
// Assumes: One oversample tick per clock, four ticks per bit
// Notes:   Queue model of the receive buffer predicts level, wake and flags
`timescale 1ns/1ps
module urx_events_tb
   import urx_pkg::*;
;
   logic       clock, rstn, sample_en, rx_pin, cts_pin, rts_level, hfc_en, cts_dis, baud_clk_en;
   logic       divisor_write, osr_write, fdm_en, dpfe_en, parity_en, parity_polarity_select, parity_odd_select;
   logic       data_check_en, rx_read, rx_data_valid, rx_data_parity_err, rts_pin, frame_error_flag;
   logic       parity_error_flag, clear_to_send_change_flag, overrun_flag, rx_threshold_flag, tx_half_empty_flag;
   logic       tx_one_left_pulse, cts_sampled, wake_request, irq, baud_clk_ready, periph_in_reset, ov, thd, p;
   logic [7:0] ovs_ratio, rx_data, d;
   logic [3:0] rx_thd_val, tx_level;
   logic [4:0] rx_level;
   logic [5:0] int_enable, int_clear;
   logic [2:0] wake_enable, wake_flag_register;
   logic [7:0] q[$];
   int         n_mismatch = 0;
   int         num_checks = 0;

   // Serial partner and device under test
   urx_serial_dev #(.BIT_CYC(4)) dev_u (.clock(clock), .rx_pin(rx_pin), .cts_pin(cts_pin));
   urx_events dut_u (.clock(clock), .rstn(rstn), .sample_en(sample_en), .ovs_ratio(ovs_ratio), .rx_pin(rx_pin),
      .cts_pin(cts_pin), .rts_level(rts_level), .hfc_en(hfc_en), .cts_dis(cts_dis), .baud_clk_en(baud_clk_en),
      .divisor_write(divisor_write), .osr_write(osr_write), .fdm_en(fdm_en), .dpfe_en(dpfe_en),
      .parity_en(parity_en), .parity_polarity_select(parity_polarity_select),
      .parity_odd_select(parity_odd_select), .data_check_en(data_check_en), .rx_thd_val(rx_thd_val),
      .tx_level(tx_level), .rx_read(rx_read), .int_enable(int_enable), .int_clear(int_clear),
      .wake_enable(wake_enable), .rts_pin(rts_pin), .rx_data(rx_data), .rx_data_valid(rx_data_valid),
      .rx_data_parity_err(rx_data_parity_err), .rx_level(rx_level), .frame_error_flag(frame_error_flag),
      .parity_error_flag(parity_error_flag), .clear_to_send_change_flag(clear_to_send_change_flag),
      .overrun_flag(overrun_flag), .rx_threshold_flag(rx_threshold_flag), .tx_half_empty_flag(tx_half_empty_flag),
      .tx_one_left_pulse(tx_one_left_pulse), .cts_sampled(cts_sampled), .wake_flag_register(wake_flag_register),
      .wake_request(wake_request), .irq(irq), .baud_clk_ready(baud_clk_ready), .periph_in_reset(periph_in_reset));

   // Clock at 50 MHz
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // Comparison and verdict
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   // Catch a one-cycle pulse into p
   task automatic hit(ref logic s);
      repeat (2) begin
         cyc(1);
         p = p | s;
      end
   endtask
   // Expected parity bit
   function automatic logic par_bit(input logic [7:0] v);
      int c;
      c = parity_polarity_select ? 8 - $countones(v) : $countones(v);
      return parity_odd_select ? (c % 2 == 1) : (c % 2 == 0);
   endfunction
   // Level and wake conditions from the model
   task automatic lv();
      logic [2:0] w;
      w = {q.size() > 0, q.size() >= 8, q.size() >= int'(rx_thd_val)} & wake_enable;
      chk(8'({rx_data_valid, rx_level}), 8'({q.size() > 0, 5'(q.size())}));
      chk(8'(wake_flag_register), 8'(w));
      chk(8'(wake_request), 8'(fdm_en && |w));
   endtask
   task automatic fl(input logic fe, input logic pe);
      chk(8'(frame_error_flag), 8'(fe));
      chk(8'(parity_error_flag), 8'(pe));
      chk(8'(overrun_flag), 8'(ov));
      chk(8'(rx_threshold_flag), 8'(thd));
   endtask
   // Good frame: stored unless full, otherwise overrun
   task automatic good(input logic [7:0] v);
      dev_u.send(v, parity_en, par_bit(v), 1'b1);
      cyc(3);
      if (q.size() < URX_FIFO_DEPTH) begin
         q.push_back(v);
         thd = thd | (q.size() > int'(rx_thd_val));
      end else begin
         ov = 1'b1;
      end
      fl(1'b0, 1'b0);
      lv();
   endtask
   task automatic clr();
      int_clear = 6'h3f;
      cyc(1);
      {int_clear, ov, thd} = '0;
      cyc(1);
   endtask
   task automatic en_wait();
      baud_clk_en = 1'b1;
      for (int i = 0; i < 20 && baud_clk_ready !== 1'b1; i++) begin
         cyc(1);
      end
      cyc(2);
   endtask

   // Main sequence
   initial begin
      void'($urandom(58698));
      {rstn, hfc_en, cts_dis, baud_clk_en, divisor_write, osr_write, fdm_en, dpfe_en, parity_en} = '0;
      {parity_polarity_select, parity_odd_select, data_check_en, rx_read, ov, thd, tx_level, int_clear} = '0;
      {sample_en, ovs_ratio, rx_thd_val, int_enable, wake_enable} = {1'b1, 8'h04, 4'h2, 6'h3f, 3'h7};
      rts_level = 1'($urandom);
      cyc(2);
      chk(8'(cts_sampled), 8'h01);
      rstn = 1'b1;
      cyc(2);
      chk(8'(periph_in_reset), 8'h01);
      en_wait();
      chk(8'({periph_in_reset, baud_clk_ready}), 8'h01);
      chk(8'(rts_pin), 8'(rts_level));
      // Every parity selection, strict checking on odd modes
      for (int m = 0; m < 4; m++) begin
         {parity_polarity_select, parity_odd_select, parity_en, fdm_en, dpfe_en} = {2'(m), 1'b1, 1'(m), 1'(m)};
         good(8'($urandom));
      end
      // Fill to full, one more overruns and is dropped
      parity_en = 1'b0;
      for (int i = 0; i < 5; i++) begin
         good(8'($urandom));
      end
      chk(8'(irq), 8'h01);
      {int_enable, wake_enable} = '0;
      cyc(2);
      lv();
      chk(8'(irq), 8'h00);
      wake_enable = 3'h7;
      cyc(2);
      while (q.size() > 0) begin
         chk(rx_data, q.pop_front());
         chk(8'(rx_data_parity_err), 8'h00);
         rx_read = 1'b1;
         cyc(1);
         rx_read = 1'b0;
         cyc(2);
         lv();
      end
      clr();
      // Wrong parity plain and strict, then a broken stop bit
      {parity_en, rx_thd_val, int_enable} = {1'b1, 4'hf, 6'h3f};
      for (int f = 0; f < 2; f++) begin
         {fdm_en, dpfe_en, d} = {1'(f), 1'(f), 8'($urandom)};
         dev_u.send(d, 1'b1, ~par_bit(d), 1'b1);
         cyc(3);
         fl(1'b1, 1'b1);
         clr();
      end
      dev_u.send(d, 1'b1, par_bit(d), 1'b0);
      cyc(3);
      fl(1'b1, 1'b0);
      // Transmit level events
      tx_level = 4'(URX_FIFO_DEPTH / 2 + 1);
      cyc(1);
      tx_level = 4'(URX_FIFO_DEPTH / 2);
      cyc(3);
      chk(8'(tx_half_empty_flag), 8'h01);
      tx_level = 4'h2;
      cyc(1);
      {tx_level, p} = {4'h1, 1'b0};
      hit(tx_one_left_pulse);
      chk(8'(p), 8'h01);
      // Clear-to-send edges, sampling disable, stopping the baud clock
      dev_u.set_cts(1'b0);
      cyc(4);
      chk(8'({cts_sampled, clear_to_send_change_flag}), 8'h01);
      clr();
      {cts_dis, rts_level} = {1'b1, ~rts_level};
      dev_u.set_cts(1'b1);
      cyc(4);
      chk(8'({cts_sampled, clear_to_send_change_flag}), 8'h00);
      chk(8'(rts_pin), 8'(rts_level));
      cts_dis = 1'b0;
      cyc(4);
      chk(8'({cts_sampled, clear_to_send_change_flag}), 8'h03);
      dev_u.set_cts(1'b0);
      cyc(4);
      baud_clk_en = 1'b0;
      cyc(3);
      chk(8'({cts_sampled, periph_in_reset}), 8'h03);
      // Divisor and rate writes while enabled
      for (int k = 0; k < 2; k++) begin
         en_wait();
         {divisor_write, osr_write} = k ? 2'b01 : 2'b10;
         cyc(1);
         {divisor_write, osr_write, p} = {2'b00, periph_in_reset};
         hit(periph_in_reset);
         chk(8'(p), 8'h01);
      end
      stop_test();
   end
   // Watchdog
   initial begin
      #200000;
      n_mismatch++;
      stop_test();
   end
endmodule
